// File: logic/display_port_latch.sv
// Display port latch: one registered halfword between CPU bus and display
//
// Functional notes
// (RQ1) One 16-bit latch holds controls and data
// (RQ2) Every access finishes at normal bus speed
// (RQ3) Host: write three, read four accesses
// (RQ4) Host: first access, strobes zero
// (RQ5) Host: second access sets needed strobes
// (RQ6) Third read returns byte from module
// (RQ7) Host: write ends with strobes idle
// (RQ8) Host: read ends with strobes idle
// (RQ9) Bit 0 drives first panel strobe
// (RQ10) Bit 1 drives second panel strobe
// (RQ11) Bit 6 drives command/data select
// (RQ12) Bit 7 drives read/write line
// (RQ13) Bits 8-15 are data lines 7-0
// (RQ14) Latch decoded at chip select base plus 0x10
// (RQ15) Responds only when map switch enables it
// (RQ16) Big-endian bits; 2-5 read zero
// (RQ17) Reset clears latch, strobes idle
`timescale 1ns/1ps
`default_nettype none
module display_port_latch #(
    parameter int addr_width = 16
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // Processor bus
    input  wire logic                  i_display_chip_select_n,
    input  wire logic [addr_width-1:0] i_addr,
    input  wire logic                  i_read_not_write,
    input  wire logic [15:0]           i_wdata,
    output logic [15:0]                o_rdata,
    output logic                       o_ack,
    // Board memory map switch bank
    input  wire logic [7:0]            i_map_switch,
    // Display module pins
    output logic                       o_first_panel_strobe,
    output logic                       o_second_panel_strobe,
    output logic                       o_cmd_data_select,
    output logic                       o_read_not_write,
    output logic [7:0]                 o_lcd_data,
    output logic                       o_lcd_data_oe,
    input  wire logic [7:0]            i_lcd_data
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic [15:0]         latch;
    logic [15:0]         read_word;
    logic                port_enabled;
    logic                hit;
    logic                access;
    display_port_pkg::bus_state_t state;
    display_port_pkg::bus_state_t next_state;

    // Switch is only a board strap, treated as a static level
    assign port_enabled = i_map_switch[display_port_pkg::map_switch_bit];  // [RQ15]
    assign hit = (i_addr[addr_width-1:0]
                  == addr_width'(display_port_pkg::latch_offset));         // [RQ14]
    assign access = ~i_display_chip_select_n & port_enabled & hit;         // [RQ15]

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking: one cycle ack, never held for the display

    always_comb begin
        next_state = display_port_pkg::st_idle;
        unique case (state)
            display_port_pkg::st_idle: begin
                if (access) begin
                    next_state = i_read_not_write ? display_port_pkg::st_read
                                                  : display_port_pkg::st_write;
                end
            end
            display_port_pkg::st_write: next_state = display_port_pkg::st_idle;
            display_port_pkg::st_read:  next_state = display_port_pkg::st_idle;
            default:                    next_state = display_port_pkg::st_idle;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= display_port_pkg::st_idle;
        end else begin
            state <= next_state;                                     // [RQ2]
        end
    end

    // Acknowledge the cycle after select, a fixed short latency
    assign o_ack = (state != display_port_pkg::st_idle);             // [RQ2]

    ////////////////////////////////////////////////////////////////////////
    // Latch

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            latch <= display_port_pkg::latch_reset;                  // [RQ17]
        end else if (state == display_port_pkg::st_idle && access
                     && !i_read_not_write) begin
            // Unused positions are never stored
            latch <= i_wdata & display_port_pkg::latch_used;         // [RQ1] [RQ16]
        end
    end

    // Read data is sampled from the pins at the access, held till next read
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (state == display_port_pkg::st_idle && access
                     && i_read_not_write) begin
            o_rdata <= read_word;                                    // [RQ6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins

    display_pin_map u_pins (
        .i_latch               (latch),
        .i_lcd_data            (i_lcd_data),
        .o_first_panel_strobe  (o_first_panel_strobe),
        .o_second_panel_strobe (o_second_panel_strobe),
        .o_cmd_data_select     (o_cmd_data_select),
        .o_read_not_write      (o_read_not_write),
        .o_lcd_data            (o_lcd_data),
        .o_lcd_data_oe         (o_lcd_data_oe),
        .o_read_word           (read_word)
    );

endmodule
`default_nettype wire

// File: logic/display_port_pkg.sv
// Constants for the display port latch on the processor memory bus
package display_port_pkg;

    // Address decode
    localparam logic [15:0] latch_offset   = 16'h0010;
    localparam int          map_switch_bit = 6;

    // Latch layout, bit 0 is the most significant bit of the halfword
    localparam int          latch_width    = 16;
    localparam int          pos_first_stb  = 0;
    localparam int          pos_second_stb = 1;
    localparam int          pos_cmd_data   = 6;
    localparam int          pos_direction  = 7;
    localparam int          pos_data_first = 8;
    localparam int          data_width     = 8;

    // Reset value: strobes idle, write direction, command select
    localparam logic [15:0] latch_reset    = 16'h0000;
    localparam logic [15:0] latch_used     = 16'hc3ff;

    // Bus cycle phases
    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_write = 3'b010,
        st_read  = 3'b100
    } bus_state_t;

endpackage

// File: logic/display_pin_map.sv
// Maps latch bits onto display module pins and reads the data lines back
`timescale 1ns/1ps
`default_nettype none
module display_pin_map (
    // Latch contents
    input  wire logic [15:0] i_latch,
    // Display data lines
    input  wire logic [7:0]  i_lcd_data,
    // Display control and data pins
    output logic             o_first_panel_strobe,
    output logic             o_second_panel_strobe,
    output logic             o_cmd_data_select,
    output logic             o_read_not_write,
    output logic [7:0]       o_lcd_data,
    output logic             o_lcd_data_oe,
    // Halfword as seen by the processor
    output logic [15:0]      o_read_word
);

    // Big-endian position p sits at vector bit 15-p
    function automatic logic pick(input logic [15:0] w, input int pos);
        pick = w[15 - pos];
    endfunction

    logic [7:0] latch_byte;

    assign o_first_panel_strobe  = pick(i_latch, display_port_pkg::pos_first_stb);  // [RQ9]
    assign o_second_panel_strobe = pick(i_latch, display_port_pkg::pos_second_stb); // [RQ10]
    assign o_cmd_data_select     = pick(i_latch, display_port_pkg::pos_cmd_data);   // [RQ11]
    assign o_read_not_write      = pick(i_latch, display_port_pkg::pos_direction);  // [RQ12]

    // Position 8 is module line 7, position 15 is line 0
    assign latch_byte    = i_latch[7:0];                                // [RQ13]
    assign o_lcd_data    = latch_byte;                                  // [RQ13]
    assign o_lcd_data_oe = ~o_read_not_write;                           // [RQ13]

    // In read direction the data byte shows the module's lines
    assign o_read_word = o_read_not_write
                       ? {i_latch[15:8] & 8'hc3, i_lcd_data}            // [RQ6]
                       : (i_latch & display_port_pkg::latch_used);      // [RQ16]

endmodule
`default_nettype wire

// File: verif/display_port_asserts.sv
// Port checker for the display port latch
`timescale 1ns/1ps
`default_nettype none
module display_port_asserts #(parameter int addr_width = 16) (
    input wire logic i_clk, i_rst_n, i_display_chip_select_n, i_read_not_write,
    input wire logic [addr_width-1:0] i_addr,
    input wire logic [15:0] i_wdata, o_rdata,
    input wire logic [7:0] i_map_switch, i_lcd_data, o_lcd_data,
    input wire logic o_ack, o_first_panel_strobe, o_second_panel_strobe,
    input wire logic o_cmd_data_select, o_read_not_write, o_lcd_data_oe);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic take;
    logic wr;
    logic [11:0] pins;
    // Busy in the ack cycle, so a held select is not taken twice
    assign take = !i_display_chip_select_n && !o_ack && i_map_switch[6] &&
                  i_addr == addr_width'(16'h0010);
    assign wr = take && !i_read_not_write;
    assign pins = {o_first_panel_strobe, o_second_panel_strobe,
                   o_cmd_data_select, o_read_not_write, o_lcd_data};
    a_ack_pulse: assert property (o_ack |=> !o_ack)
        else $error("ack too long");
    a_ack_taken: assert property (take |=> o_ack)
        else $error("no ack");
    a_ack_refused: assert property (!take |=> !o_ack)
        else $error("stray ack");
    a_pin_map: assert property (wr |=> pins ==
        $past({i_wdata[15:14], i_wdata[9:0]})) else $error("pin map");
    a_oe_dir: assert property (o_lcd_data_oe == !o_read_not_write)
        else $error("oe");
    a_read_word: assert property (take && i_read_not_write |=> o_rdata ==
        {pins[11:10], 4'h0, pins[9:8], pins[8] ? $past(i_lcd_data) : pins[7:0]})
        else $error("read word");
    a_pins_hold: assert property (!wr |=> $stable(pins))
        else $error("pins moved");
    a_reset_idle: assert property (disable iff (1'b0) !i_rst_n |=>
        !o_first_panel_strobe && !o_second_panel_strobe) else $error("reset");
endmodule
bind display_port_latch display_port_asserts #(.addr_width(addr_width)) u_chk (.*);
`default_nettype wire

// File: verif/lcd_module_model.sv
// Behavioural display module on the far side of the latch
`timescale 1ns/1ps
`default_nettype none
module lcd_module_model (
    input  wire logic       i_clk,
    input  wire logic       i_strobe,
    input  wire logic       i_read,
    input  wire logic [7:0] i_data,
    output logic [7:0]      o_data
);
    logic [7:0] mem = 8'ha5;
    logic [7:0] last = 8'h00;
    logic       was = 1'b0;
    // Byte taken as the strobe falls, as a real module does
    always @(posedge i_clk) begin
        was <= i_strobe;
        if (was && !i_strobe && !i_read)
            mem <= i_data;
        if (i_strobe && i_read)
            last <= mem;
    end
    // Released lines show the inverse, so a stale byte cannot pass
    assign o_data = (i_strobe && i_read) ? mem : ~last;
endmodule
`default_nettype wire

// File: verif/tb_lcd_register_port.sv
// Self-checking bench for the display port latch
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_register_port;
    logic        i_clk, i_rst_n, i_display_chip_select_n, i_read_not_write;
    logic [15:0] i_addr, i_wdata, o_rdata;
    logic [7:0]  i_map_switch, i_lcd_data, o_lcd_data;
    logic        o_ack, o_first_panel_strobe, o_second_panel_strobe;
    logic        o_cmd_data_select, o_read_not_write, o_lcd_data_oe;
    int          fails = 0;
    int          checked = 0;
    display_port_latch dut_u (.*);
    lcd_module_model lcd_u (
        .i_clk    (i_clk),
        .i_strobe (o_first_panel_strobe | o_second_panel_strobe),
        .i_read   (o_read_not_write),
        .i_data   (o_lcd_data),
        .o_data   (i_lcd_data));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        fails++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] pins();
        return {o_first_panel_strobe, o_second_panel_strobe, 4'h0,
                o_cmd_data_select, o_read_not_write, o_lcd_data};
    endfunction
    // Select is dropped in the ack cycle, leaving one idle cycle
    task automatic access(logic r, logic [15:0] a, d, logic acked);
        @(posedge i_clk);
        #1;
        i_display_chip_select_n = 1'b0;
        i_read_not_write = r;
        i_addr = a;
        i_wdata = d;
        for (int n = 0; n < 4 && o_ack !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        check("ack", {15'h0, acked}, {15'h0, o_ack});
        i_display_chip_select_n = 1'b1;
    endtask
    task automatic write_transfers();
        logic [15:0] w;
        for (int i = 0; i < 3; i++) begin
            w = {2'b00, 4'hf, i[0], 1'b0, 8'h31 + 8'(i)};
            access(1'b0, 16'h0010, w, 1'b1);
            check("first", w & 16'h03ff, pins());
            access(1'b0, 16'h0010, w | {2'(i + 1), 14'h0}, 1'b1);
            check("strobe", (w & 16'h03ff) | {2'(i + 1), 14'h0}, pins());
            access(1'b0, 16'h0010, w, 1'b1);
            check("idle", w & 16'h03ff, pins());
        end
    endtask
    task automatic read_transfer();
        access(1'b0, 16'h0010, 16'h0300, 1'b1);
        access(1'b0, 16'h0010, 16'h8300, 1'b1);
        check("oe", 16'h0000, {15'h0, o_lcd_data_oe});
        access(1'b1, 16'h0010, 16'h0000, 1'b1);
        check("read", 16'h8333, o_rdata);
        access(1'b0, 16'h0010, 16'h0300, 1'b1);
        check("end", 16'h0300, pins());
    endtask
    task automatic refused();
        access(1'b0, 16'h0012, 16'hc0ff, 1'b0);
        i_map_switch = 8'hbf;
        access(1'b0, 16'h0010, 16'hc0ff, 1'b0);
        i_map_switch = 8'h40;
        check("kept", 16'h0300, pins());
    endtask
    task automatic close_out();
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {i_display_chip_select_n, i_read_not_write, i_addr, i_wdata} = '1;
        i_map_switch = 8'h40;
        i_rst_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        check("reset", 16'h0000, pins());
        write_transfers();
        read_transfer();
        refused();
        close_out();
    end
endmodule
`default_nettype wire
